// ### hdl/sdmr_consts.svh
// constants for the mode register zero and burst ordering block
`ifndef SDMR_CONSTS_SVH
`define SDMR_CONSTS_SVH

// ---------------------------------------------------------------
// field positions of mode register zero
// ---------------------------------------------------------------
`define SDMR_BL_LSB        0
`define SDMR_BT_BIT        3
`define SDMR_CL_LSB        4
`define SDMR_TM_BIT        7
`define SDMR_DLLRST_BIT    8
`define SDMR_WR_LSB        9
`define SDMR_PPD_BIT       12
`define SDMR_BC_ADDR_BIT   12
`define SDMR_MR_RESET      16'h0000

// ---------------------------------------------------------------
// burst length codes
// ---------------------------------------------------------------
`define SDMR_BL_FIX8       2'h0
`define SDMR_BL_OTF        2'h1
`define SDMR_BL_FIX4       2'h2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SDMR_CLK_NS        20
`define SDMR_TMOD_CYC      12
`define SDMR_TDLLK_CYC     512
`define SDMR_CHOP_EARLY    2

`endif

// ### hdl/sdmr_core.sv
// mode register zero decode, burst ordering and write timing
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "sdmr_consts.svh"
module sdmr_core
	import sdmr_pkg::*;
#(
	parameter int FIFO_DEPTH = 8,
	parameter int TDLLK_CYC  = `SDMR_TDLLK_CYC
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         cke,
	input  wire sdmr_cmd_type cmd,
	input  wire logic         initDone,
	input  wire logic         rwValid,
	input  wire logic         rwIsWrite,
	output var  logic         rwReady,
	output var  sdmr_beat_type beat,
	output var  logic         beatValid,
	output var  logic         ready,
	output var  logic         settling,
	output var  logic         dllLocked,
	output var  logic [15:0]  modeReg,
	output var  logic [2:0]   casLatency,
	output var  logic [2:0]   writeRecovery,
	output var  logic [1:0]   regWritten,
	output var  logic         dllFastExit
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0]     ckeSync;
		logic [15:0]    mr;
		logic [3:0]     written;
		logic [3:0]     modCnt;
		logic [15:0]    dllCnt;
		logic           initSeen;
		sdmr_phase_type phase;
		sdmr_req_type   cur;
		logic [2:0]     slot;
		logic [1:0]     delay;
		sdmr_beat_type  beat;
		logic           beatValid;
	} sdmr_state_type;

	sdmr_state_type st;
	sdmr_state_type next_st;

	logic        isMrs;
	logic        isRw;
	logic        chopNow;
	logic [1:0]  blCode;
	logic        interleave;
	logic        fifoInReady;
	logic        fifoOutValid;
	logic        fifoOutReady;
	logic [4:0]  fifoOutData;
	sdmr_req_type fifoReq;
	sdmr_req_type newReq;

	// order of beat k from start column, shared by both lengths
	function automatic logic [2:0] beatIndex(input logic [2:0] start,
		input logic [2:0] k, input logic inter);
		logic [2:0] r;
		r = '0;
		if (inter) begin
			r = start ^ k;
		end else begin
			r[1:0] = start[1:0] + k[1:0];
			r[2]   = start[2] ^ k[2];
		end
		return r;
	endfunction

	function automatic logic chopFor(input logic [1:0] code, input logic a12);
		logic c;
		c = 1'b0;
		unique case (code)
			`SDMR_BL_FIX8: c = 1'b0;
			`SDMR_BL_OTF:  c = ~a12;
			`SDMR_BL_FIX4: c = 1'b1;
			default:       c = 1'b0;
		endcase
		return c;
	endfunction

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	// mode register one to three live elsewhere; only writes counted
	assign isMrs = st.ckeSync[1] && !cmd.csN && !cmd.rasN && !cmd.casN
		&& !cmd.weN;
	assign isRw  = st.ckeSync[1] && !cmd.csN && cmd.rasN && !cmd.casN;
	assign blCode     = st.mr[`SDMR_BL_LSB +: 2];
	assign interleave = st.mr[`SDMR_BT_BIT];
	assign chopNow    = chopFor(blCode, cmd.addr[`SDMR_BC_ADDR_BIT]);

	assign newReq.isWrite = rwIsWrite;
	assign newReq.chop    = chopNow;
	assign newReq.column  = cmd.addr[2:0];
	assign fifoReq        = sdmr_req_type'(fifoOutData);
	assign fifoOutReady   = (st.phase == SDMR_IDLE);
	// back-pressure: requests stall while the queue is full
	assign rwReady        = fifoInReady && ready;

	sdmr_fifo #(
		.WIDTH (5),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.nrst     (nrst),
		.inValid  (rwValid && isRw && ready),
		.inReady  (fifoInReady),
		.inData   (newReq),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ckeSync = {st.ckeSync[0], cke};
		next_st.beatValid = 1'b0;
		next_st.beat = st.beat;
		if (st.modCnt != 4'h0) begin
			next_st.modCnt = st.modCnt - 4'h1;
		end
		if (st.dllCnt != 16'h0000) begin
			next_st.dllCnt = st.dllCnt - 16'h0001;
		end
		if (initDone) begin
			next_st.initSeen = 1'b1;
		end
		if (isMrs) begin
			next_st.written[cmd.bank[1:0]] = 1'b1;
			next_st.modCnt = 4'(`SDMR_TMOD_CYC);
			if (cmd.bank == 3'h0) begin
				// reserved bits forced to zero in case they arrive set
				next_st.mr = {3'h0, cmd.addr[12:0]};
				next_st.mr[`SDMR_DLLRST_BIT] = 1'b0;
				if (cmd.addr[`SDMR_DLLRST_BIT]) begin
					next_st.dllCnt = 16'(TDLLK_CYC);
				end
			end
		end
		unique case (st.phase)
			SDMR_IDLE: begin
				if (fifoOutValid) begin
					next_st.cur   = fifoReq;
					next_st.phase = SDMR_BURST;
					next_st.slot  = 3'h0;
					// fixed chop writes start early; otf chop does not
					next_st.delay = (fifoReq.isWrite && !(fifoReq.chop
						&& blCode == `SDMR_BL_FIX4)) ? 2'(`SDMR_CHOP_EARLY)
						: 2'h0;
				end
			end
			SDMR_BURST: begin
				if (st.delay != 2'h0) begin
					next_st.delay = st.delay - 2'h1;
				end else begin
					next_st.beatValid = 1'b1;
					if (st.cur.isWrite) begin
						next_st.beat.index = st.slot;
						if (st.cur.chop) begin
							next_st.beat.index = {st.cur.column[2], st.slot[1:0]};
						end
						next_st.beat.store = !(st.cur.chop && st.slot[2]);
						next_st.beat.drive = 1'b0;
					end else begin
						next_st.beat.index = beatIndex(st.cur.column, st.slot,
							interleave);
						next_st.beat.drive = !(st.cur.chop && st.slot[2]);
						next_st.beat.store = 1'b0;
					end
					next_st.beat.last = (st.slot == 3'h7);
					next_st.slot = st.slot + 3'h1;
					if (st.slot == 3'h7) begin
						next_st.phase = SDMR_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.mr <= `SDMR_MR_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign beat          = st.beat;
	assign beatValid     = st.beatValid;
	assign ready         = st.initSeen && (st.written == 4'hF);
	assign settling      = (st.modCnt != 4'h0);
	assign dllLocked     = (st.dllCnt == 16'h0000);
	assign modeReg       = st.mr;
	assign casLatency    = st.mr[`SDMR_CL_LSB +: 3];
	assign writeRecovery = st.mr[`SDMR_WR_LSB +: 3];
	assign regWritten    = blCode;
	assign dllFastExit   = st.mr[`SDMR_PPD_BIT];
endmodule
`default_nettype wire

// ### hdl/sdmr_fifo.sv
// small valid/ready fifo for burst requests
`timescale 1ns/1ns
`default_nettype none
module sdmr_fifo
	import sdmr_pkg::*;
#(
	parameter int WIDTH = 5,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             outValid,
	input  wire logic             outReady,
	output var  logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   count;
	} sdmr_fstate_type;

	sdmr_fstate_type st;
	sdmr_fstate_type next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             doPush;
	logic             doPop;

	assign inReady  = (st.count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign outValid = (st.count != '0);
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;
	assign outData  = mem[st.rp];

	always_comb begin
		next_st = st;
		if (doPush) begin
			next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + AW'(1);
		end
		if (doPop) begin
			next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + AW'(1);
		end
		if (doPush && !doPop) begin
			next_st.count = st.count + (AW+1)'(1);
		end else if (doPop && !doPush) begin
			next_st.count = st.count - (AW+1)'(1);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// storage needs no reset; contents are guarded by count
	always_ff @(posedge clock) begin
		if (doPush) begin
			mem[st.wp] <= inData;
		end
	end
endmodule
`default_nettype wire

// ### hdl/sdmr_pkg.sv
// types shared by the mode register block
package sdmr_pkg;

	typedef enum logic [1:0] {
		SDMR_IDLE,
		SDMR_BURST
	} sdmr_phase_type;

	typedef struct packed {
		logic        csN;
		logic        rasN;
		logic        casN;
		logic        weN;
		logic [2:0]  bank;
		logic [15:0] addr;
	} sdmr_cmd_type;

	typedef struct packed {
		logic       isWrite;
		logic       chop;
		logic [2:0] column;
	} sdmr_req_type;

	typedef struct packed {
		logic [2:0] index;
		logic       drive;
		logic       store;
		logic       last;
	} sdmr_beat_type;

endpackage

// ### verif/sdmr_core_assertions.sv
// concurrent checks on the mode register and burst ports
`timescale 1ns/1ns
`default_nettype none
module sdmr_core_assertions
	import sdmr_pkg::*;
#(
	parameter int TDLLK_CYC = 8
) (
	input  wire logic          clock,
	input  wire logic          nrst,
	input  wire sdmr_cmd_type  cmd,
	input  wire logic          rwReady,
	input  wire sdmr_beat_type beat,
	input  wire logic          beatValid,
	input  wire logic          ready,
	input  wire logic          settling,
	input  wire logic          dllLocked,
	input  wire logic [15:0]   modeReg,
	input  wire logic [2:0]    casLatency,
	input  wire logic [2:0]    writeRecovery,
	input  wire logic [1:0]    regWritten,
	input  wire logic          dllFastExit
);
	// counts cycles of an unlocked delay line
	int lowCnt;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			lowCnt <= 0;
		else
			lowCnt <= dllLocked ? 0 : lowCnt + 1;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	a_mr_cause: assert property (!$stable(modeReg) |-> $past(cmd[22:16]) == 7'h00)
		else $error("mode register moved without a write");
	a_reserved_zero: assert property (modeReg[15:13] == 3'h0)
		else $error("reserved bits not zero");
	a_dll_selfclear: assert property (modeReg[8] == 1'b0)
		else $error("delay line reset bit stuck");
	a_dll_wait: assert property ($rose(dllLocked) |-> lowCnt == TDLLK_CYC)
		else $error("lock wait length wrong");
	a_cas_field: assert property (casLatency == modeReg[6:4])
		else $error("latency field wrong");
	a_wr_field: assert property (writeRecovery == modeReg[11:9])
		else $error("recovery field wrong");
	a_len_field: assert property (regWritten == modeReg[1:0] && dllFastExit == modeReg[12])
		else $error("length or exit field wrong");
	a_settle_span: assert property ($fell(settling) |-> $past(settling, 12))
		else $error("settle span too short");
	a_settle_cause: assert property ($rose(settling) |-> $past(cmd[22:19]) == 4'h0)
		else $error("settle without a write");
	a_burst_run: assert property (beatValid && beat.last |-> $past(beatValid, 7))
		else $error("burst not eight beats");
	a_rw_gate: assert property (rwReady |-> ready)
		else $error("accepting before init");
endmodule
bind sdmr_core sdmr_core_assertions #(.TDLLK_CYC(TDLLK_CYC)) sdmr_core_assertions_inst (
	.clock(clock), .nrst(nrst), .cmd(cmd), .rwReady(rwReady), .beat(beat),
	.beatValid(beatValid), .ready(ready), .settling(settling), .dllLocked(dllLocked),
	.modeReg(modeReg), .casLatency(casLatency), .writeRecovery(writeRecovery),
	.regWritten(regWritten), .dllFastExit(dllFastExit));
`default_nettype wire

// ### verif/sdmr_core_tb.sv
// self-checking bench for the mode register and burst block
`timescale 1ns/1ns
`default_nettype none
module sdmr_core_tb
	import sdmr_pkg::*;
;
	logic          clock, nrst, cke, initDone, rwValid, rwIsWrite, rwReady;
	logic          beatValid, ready, settling, dllLocked, dllFastExit, full;
	sdmr_cmd_type  cmd;
	sdmr_beat_type beat;
	logic [15:0]   modeReg;
	logic [2:0]    casLatency, writeRecovery;
	logic [1:0]    regWritten;
	int            badCount, checksDone, lat, latRd, latW8;
	sdmr_core #(.TDLLK_CYC(8)) sdmr_core_inst (
		.clock(clock), .nrst(nrst), .cke(cke), .cmd(cmd), .initDone(initDone),
		.rwValid(rwValid), .rwIsWrite(rwIsWrite), .rwReady(rwReady), .beat(beat),
		.beatValid(beatValid), .ready(ready), .settling(settling), .dllLocked(dllLocked),
		.modeReg(modeReg), .casLatency(casLatency), .writeRecovery(writeRecovery),
		.regWritten(regWritten), .dllFastExit(dllFastExit));
	sdmr_ctrl_model sdmr_ctrl_model_inst (.clock(clock), .cke(cke), .cmd(cmd),
		.rwValid(rwValid), .rwIsWrite(rwIsWrite));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			badCount++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// whole register rewritten, then tMOD respected before traffic
	task automatic setMode(input logic [1:0] bl, input logic bt);
		sdmr_ctrl_model_inst.mrs(3'h0, {4'h1, 3'h5, 2'h0, 3'h2, bt, 1'b0, bl});
		tick(14);
	endtask
	task automatic burst(input logic w, input logic [2:0] c, input logic bc,
		input logic bt, input logic chop);
		logic [2:0] i;
		logic       on;
		chk(rwReady, 1'b1);
		sdmr_ctrl_model_inst.rw(w, c, bc);
		#1;
		lat = 0;
		while (beatValid !== 1'b1 && lat < 20) begin
			tick(1);
			lat++;
		end
		for (int k = 0; k < 8; k++) begin
			i = k[2:0];
			on = !(chop && k > 3);
			if (on)
				chk(beat.index, w ? (chop ? {c[2], i[1:0]} : i) :
					(bt ? c ^ i : {c[2] ^ i[2], c[1:0] + i[1:0]}));
			chk({beatValid, beat.drive, beat.store, beat.last}, {1'b1, !w && on, w && on, k == 7});
			tick(1);
		end
	endtask
	initial begin
		nrst = 1'b0;
		initDone = 1'b0;
		badCount = 0;
		checksDone = 0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		tick(1);
		chk({ready, rwReady, dllLocked}, 3'b001);
		sdmr_ctrl_model_inst.setCke(1'b1);
		tick(4);
		sdmr_ctrl_model_inst.mrs(3'h2, 16'h0000);
		sdmr_ctrl_model_inst.mrs(3'h3, 16'h0000);
		sdmr_ctrl_model_inst.mrs(3'h1, 16'h0000);
		sdmr_ctrl_model_inst.mrs(3'h0, 16'hFB20);
		tick(2);
		chk(modeReg, 16'h1A20);
		chk({casLatency, writeRecovery, regWritten, dllFastExit, settling, dllLocked},
			{3'h2, 3'h5, 2'h0, 3'b110});
		tick(20);
		chk({dllLocked, settling, ready}, 3'b100);
		@(posedge clock);
		initDone <= 1'b1;
		tick(2);
		chk(ready, 1'b1);
		$display("init test done");
		for (int bt = 0; bt < 2; bt++) begin
			setMode(2'h0, bt[0]);
			for (int c = 0; c < 8; c++)
				burst(1'b0, c[2:0], 1'b0, bt[0], 1'b0);
			latRd = lat;
			setMode(2'h2, bt[0]);
			for (int c = 0; c < 8; c++)
				burst(1'b0, c[2:0], 1'b0, bt[0], 1'b1);
		end
		$display("read order test done");
		setMode(2'h0, 1'b0);
		burst(1'b1, 3'h5, 1'b0, 1'b0, 1'b0);
		latW8 = lat;
		setMode(2'h2, 1'b0);
		burst(1'b1, 3'h5, 1'b0, 1'b0, 1'b1);
		chk(lat + 2, latW8);
		chk(lat, latRd);
		setMode(2'h1, 1'b0);
		burst(1'b1, 3'h6, 1'b0, 1'b0, 1'b1);
		chk(lat, latW8);
		burst(1'b0, 3'h3, 1'b1, 1'b0, 1'b0);
		burst(1'b0, 3'h3, 1'b0, 1'b0, 1'b1);
		$display("write timing test done");
		// queue is fed faster than bursts drain, so it must refuse
		full = 1'b0;
		repeat (14) begin
			sdmr_ctrl_model_inst.rw(1'b0, 3'h0, 1'b1);
			#1 full = full | !rwReady;
		end
		chk(full, 1'b1);
		tick(160);
		chk({rwReady, beatValid}, 2'b10);
		$display("queue test done");
		sdmr_ctrl_model_inst.setCke(1'b0);
		@(posedge clock);
		nrst <= 1'b0;
		initDone <= 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		tick(2);
		chk(modeReg, 16'h0000);
		chk(ready, 1'b0);
		$display("warm reset test done");
		giveVerdict();
	end
	initial begin
		repeat (20000) @(posedge clock);
		badCount++;
		giveVerdict();
	end
endmodule
`default_nettype wire

// ### verif/sdmr_ctrl_model.sv
// memory controller model driving the command bus
`timescale 1ns/1ns
`default_nettype none
module sdmr_ctrl_model
	import sdmr_pkg::*;
(
	input  wire logic         clock,
	output var  logic         cke,
	output var  sdmr_cmd_type cmd,
	output var  logic         rwValid,
	output var  logic         rwIsWrite
);
	// idle address is inverted so stale values never match
	task automatic idle(input logic [15:0] a);
		cmd <= '{1'b0, 1'b1, 1'b1, 1'b1, 3'h7, ~a};
		rwValid <= 1'b0;
	endtask
	task automatic setCke(input logic v);
		@(posedge clock);
		cke <= v;
	endtask
	task automatic mrs(input logic [2:0] b, input logic [15:0] a);
		@(posedge clock);
		cmd <= '{1'b0, 1'b0, 1'b0, 1'b0, b, a};
		@(posedge clock);
		idle(a);
	endtask
	task automatic rw(input logic w, input logic [2:0] c, input logic bc);
		@(posedge clock);
		cmd <= '{1'b0, 1'b1, 1'b0, ~w, 3'h0, {3'h0, bc, 9'h000, c}};
		rwValid <= 1'b1;
		rwIsWrite <= w;
		@(posedge clock);
		idle({3'h0, bc, 9'h000, c});
	endtask
	initial begin
		cke = 1'b0;
		rwIsWrite = 1'b0;
		idle(16'h0000);
	end
endmodule
`default_nettype wire
